// file: src/flash_iap_command_port.sv
// Flash in-application programming command port with an APB slave.
// Assumes a flash macro on the same clock that takes a one-cycle start
// with a request word and answers erase/program with a one-cycle done,
// and returns read data on flash_rdata the cycle after a read start.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Config top bit: last command ignored or completed
// - Self-program enable low ignores all commands
// - Pin-boot flag set when both pins low
// - Info index selects readback item
// - Command register: 7-bit code, reserved top, reset 0
// - Decode chip, sector, partition erase and program
// - Byte verify is quick and never interrupts
// - Secure page chosen by high address 90H-94H
// - Chip security selected by high address B0H-B3H
// - Boot options E0H-E2H and user boot vector
// - Unlisted codes start nothing
// - Low address mailbox holds flash address low
// - High address mailbox holds upper byte or selector
// - Data mailbox carries program or verify byte
// - Info register returns identity, vector, security
module flash_iap_command_port
  import flash_iap_pkg::*;
#(
  parameter logic [7:0] MAKER_ID      = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEVICE_ID0    = 8'h3C, // Arbitrary value
  parameter logic [7:0] DEVICE_ID1    = 8'h2D, // Arbitrary value
  parameter logic [7:0] UNLOCK_1_VAL  = 8'hAA,
  parameter logic [7:0] UNLOCK_2_VAL  = 8'h55
) (
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire logic          ce,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output var  logic [31:0]   prdata,
  output var  logic          pready,
  output var  logic          pslverr,
  output var  logic          irq,
  input  wire logic [1:0]    port1_pins,
  output var  flash_req_type flash_req,
  output var  logic          flash_start,
  input  wire logic          flash_done,
  input  wire logic [7:0]    flash_rdata
);

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_WAIT   = 2'b01,
    ST_VERIFY = 2'b10,
    ST_FETCH  = 2'b11
  } state_type;

  state_type state_q;
  logic [7:0] config_q;
  logic [7:0] command_q;
  logic [7:0] addr_low_q;
  logic [7:0] addr_high_q;
  logic [7:0] data_q;
  logic [PAGE_COUNT-1:0] page_sec_q;
  logic [CHIP_COUNT-1:0] chip_sec_q;
  logic [BOOT_COUNT-1:0] boot_opt_q;
  logic [7:0] boot_vec_q;
  logic [IRQ_W-1:0] irq_status_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [1:0] unlock_q;
  logic [1:0] pins_meta_q;
  logic [1:0] pins_sync_q;
  logic [1:0] boot_wait_q;
  logic       boot_seen_q;
  logic       pready_q;
  logic       pslverr_q;
  logic [31:0] prdata_q;
  logic       irq_q;
  logic       start_q;
  flash_req_type req_q;

  logic       access;
  logic       wr_en;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic       mapped;
  logic       cmd_write;
  logic       accept;
  logic       ignore;
  logic       finish;
  logic       verify_end;
  logic       done_event;
  logic [7:0] info_byte;
  logic [7:0] rd_byte;
  logic [7:0] page_off;
  logic [7:0] chip_off;
  logic [7:0] boot_off;
  logic       page_hit;
  logic       chip_hit;
  logic       boot_hit;
  logic       op_valid;
  logic       op_instant;
  flash_op_type fop;

  assign access = psel & penable & pready_q;
  assign wr_en  = access & pwrite & ~pslverr_q;
  assign idx    = paddr[9:2];
  assign wbyte  = pwdata[7:0];
  assign cmd_write = wr_en & (idx == IDX_COMMAND);

  // Sub-command selector decode
  assign page_off = addr_high_q - SEL_PAGE_BASE;
  assign chip_off = addr_high_q - SEL_CHIP_BASE;
  assign boot_off = addr_high_q - SEL_BOOT_BASE;
  assign page_hit = page_off < 8'(PAGE_COUNT);
  assign chip_hit = chip_off < 8'(CHIP_COUNT);
  assign boot_hit = boot_off < 8'(BOOT_COUNT);

  always_comb begin
    fop        = FOP_NONE;
    op_valid   = 1'b1;
    op_instant = 1'b0;
    case (wbyte[6:0])
      OP_CHIP_ERASE:   fop = FOP_CHIP_ERASE;
      OP_SECTOR_ERASE: fop = FOP_SECT_ERASE;
      OP_PART0_ERASE:  fop = FOP_PART0_ERASE;
      OP_BYTE_PROGRAM: fop = FOP_PROGRAM;
      OP_BYTE_VERIFY:  fop = FOP_READ;
      OP_SECURE_PAGE: begin
        op_valid   = page_hit;
        op_instant = 1'b1;
      end
      OP_SECURE_CHIP: begin
        op_valid   = chip_hit;
        op_instant = 1'b1;
      end
      OP_BOOT_OPTION: begin
        op_valid   = boot_hit;
        op_instant = 1'b1;
      end
      OP_BOOT_VECTOR: op_instant = 1'b1;
      default:        op_valid = 1'b0;
    endcase
  end

  // Busy engine, missing unlock, disabled or unknown code: no operation
  assign accept = cmd_write & (state_q == ST_IDLE) & (unlock_q == 2'd2)
                & config_q[CFG_ENABLE_BIT] & op_valid;
  assign ignore = cmd_write & ~accept;
  assign verify_end = (state_q == ST_VERIFY);
  assign finish = (accept & op_instant)
                | ((state_q == ST_WAIT) & flash_done)
                | verify_end;
  // Verify completion raises no interrupt event
  assign done_event = finish & ~verify_end;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      start_q <= 1'b0;
      req_q   <= '0;
    end else if (ce) begin
      start_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (accept && fop != FOP_NONE) begin
            start_q <= 1'b1;
            // Mailboxes frozen into the request at the write
            req_q.op    <= fop;
            req_q.addr  <= {addr_high_q, addr_low_q};
            req_q.wdata <= data_q;
            state_q <= (fop == FOP_READ) ? ST_FETCH : ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (flash_done) begin
            state_q <= ST_IDLE;
          end
        end
        ST_FETCH:  state_q <= ST_VERIFY;
        ST_VERIFY: state_q <= ST_IDLE;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // Unlock pair: first then second write, no other write between
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      unlock_q <= 2'd0;
    end else if (ce && wr_en) begin
      if (idx == IDX_UNLOCK_1 && wbyte == UNLOCK_1_VAL) begin
        unlock_q <= 2'd1;
      end else if (idx == IDX_UNLOCK_2 && wbyte == UNLOCK_2_VAL
                   && unlock_q == 2'd1) begin
        unlock_q <= 2'd2;
      end else begin
        unlock_q <= 2'd0;
      end
    end
  end

  // Strap pins are asynchronous; caught four cycles after the release
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pins_meta_q <= 2'b11;
      pins_sync_q <= 2'b11;
      boot_wait_q <= 2'd0;
      boot_seen_q <= 1'b0;
    end else if (ce) begin
      pins_meta_q <= port1_pins;
      pins_sync_q <= pins_meta_q;
      if (boot_wait_q != 2'd3) begin
        boot_wait_q <= boot_wait_q + 2'd1;
      end else if (!boot_seen_q) begin
        boot_seen_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      config_q <= CONFIG_RESET;
    end else if (ce) begin
      if (wr_en && idx == IDX_CONFIG) begin
        config_q[CFG_ENABLE_BIT] <= wbyte[CFG_ENABLE_BIT];
        config_q[CFG_INDEX_LSB +: CFG_INDEX_W] <=
          wbyte[CFG_INDEX_LSB +: CFG_INDEX_W];
      end
      if (boot_wait_q == 2'd3 && !boot_seen_q) begin
        config_q[CFG_PINBOOT_BIT] <= (pins_sync_q == 2'b00);
      end
      if (ignore) begin
        config_q[CFG_STATUS_BIT] <= 1'b0;
      end else if (accept) begin
        config_q[CFG_STATUS_BIT] <= op_instant;
      end else if (finish) begin
        config_q[CFG_STATUS_BIT] <= 1'b1;
      end
    end
  end

  // Mailboxes; a verify result overrides a same-cycle software write
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      command_q   <= COMMAND_RESET;
      addr_low_q  <= 8'h00;
      addr_high_q <= 8'h00;
      data_q      <= 8'h00;
    end else if (ce) begin
      if (cmd_write) begin
        command_q <= {1'b0, wbyte[6:0]};
      end
      if (wr_en && idx == IDX_ADDR_LOW) begin
        addr_low_q <= wbyte;
      end
      if (wr_en && idx == IDX_ADDR_HIGH) begin
        addr_high_q <= wbyte;
      end
      if (verify_end) begin
        data_q <= flash_rdata;
      end else if (wr_en && idx == IDX_DATA) begin
        data_q <= wbyte;
      end
    end
  end

  // Security and boot option bits, cleared only by reset; boot vector reloaded by each vector command
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      page_sec_q <= '0;
      chip_sec_q <= '0;
      boot_opt_q <= '0;
      boot_vec_q <= 8'h00;
    end else if (ce && accept) begin
      case (wbyte[6:0])
        OP_SECURE_PAGE: page_sec_q[page_off[2:0]] <= 1'b1;
        OP_SECURE_CHIP: chip_sec_q[chip_off[1:0]] <= 1'b1;
        OP_BOOT_OPTION: boot_opt_q[boot_off[1:0]] <= 1'b1;
        OP_BOOT_VECTOR: boot_vec_q <= data_q;
        default: ;
      endcase
    end
  end

  // Sticky events: hardware set wins over a same-cycle clear
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_status_q <= '0;
      irq_mask_q   <= '0;
      irq_q        <= 1'b0;
    end else if (ce) begin
      if (wr_en && idx == IDX_IRQ_MASK) begin
        irq_mask_q <= wbyte[IRQ_W-1:0];
      end
      for (int i = 0; i < IRQ_W; i++) begin
        if ((i == IRQ_DONE_BIT && done_event)
            || (i == IRQ_IGNORED_BIT && ignore)) begin
          irq_status_q[i] <= 1'b1;
        end else if (wr_en && idx == IDX_IRQ_STATUS && wbyte[i]) begin
          irq_status_q[i] <= 1'b0;
        end
      end
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  always_comb begin
    case (config_q[CFG_INDEX_LSB +: CFG_INDEX_W])
      INFO_MAKER:   info_byte = MAKER_ID;
      INFO_DEV0:    info_byte = DEVICE_ID0;
      INFO_DEV1:    info_byte = DEVICE_ID1;
      INFO_VECTOR:  info_byte = boot_vec_q;
      INFO_PAGESEC: info_byte = {3'b000, page_sec_q};
      INFO_CHIPSEC: info_byte = {1'b0, boot_opt_q, chip_sec_q};
      default:      info_byte = 8'h00;
    endcase
  end

  always_comb begin
    mapped  = 1'b1;
    rd_byte = 8'h00;
    case (idx)
      IDX_CONFIG:     rd_byte = config_q;
      IDX_COMMAND:    rd_byte = command_q;
      IDX_ADDR_LOW:   rd_byte = addr_low_q;
      IDX_ADDR_HIGH:  rd_byte = addr_high_q;
      IDX_DATA:       rd_byte = data_q;
      IDX_INFO:       rd_byte = info_byte;
      IDX_UNLOCK_1:   rd_byte = 8'h00;
      IDX_UNLOCK_2:   rd_byte = 8'h00;
      IDX_IRQ_STATUS: rd_byte = {6'b00_0000, irq_status_q};
      IDX_IRQ_MASK:   rd_byte = {6'b00_0000, irq_mask_q};
      default:        mapped  = 1'b0;
    endcase
    if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end
  end

  // One wait state so read data and error come from flip-flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      if (psel && penable && !pready_q) begin
        prdata_q <= (pwrite || !mapped) ? 32'h0000_0000
                                        : {24'h00_0000, rd_byte};
      end
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign irq         = irq_q;
  assign flash_req   = req_q;
  assign flash_start = start_q;

endmodule : flash_iap_command_port

`default_nettype wire

// file: src/flash_iap_pkg.sv
// Package for the flash command port: register indices, field layout,
// reset values, operation codes and the flash-side request carrier.
// Assumes an APB master with word-aligned byte addresses (index * 4).
package flash_iap_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONFIG     = 8'hB1;
  localparam logic [7:0] IDX_COMMAND    = 8'hB2;
  localparam logic [7:0] IDX_ADDR_LOW   = 8'hB3;
  localparam logic [7:0] IDX_ADDR_HIGH  = 8'hB4;
  localparam logic [7:0] IDX_DATA       = 8'hB5;
  localparam logic [7:0] IDX_INFO       = 8'hB6;
  localparam logic [7:0] IDX_UNLOCK_1   = 8'h97;
  localparam logic [7:0] IDX_UNLOCK_2   = 8'hC4;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hC8;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'hC9;

  // Configuration register fields
  localparam int CFG_STATUS_BIT = 7;
  localparam int CFG_ENABLE_BIT = 6;
  localparam int CFG_PINBOOT_BIT = 4;
  localparam int CFG_INDEX_LSB  = 0;
  localparam int CFG_INDEX_W    = 3;
  localparam logic [7:0] CONFIG_RESET  = 8'h80;
  localparam logic [7:0] COMMAND_RESET = 8'h00;

  // Interrupt status bits
  localparam int IRQ_DONE_BIT    = 0;
  localparam int IRQ_IGNORED_BIT = 1;
  localparam int IRQ_W           = 2;

  // Operation codes
  localparam logic [6:0] OP_CHIP_ERASE   = 7'h01;
  localparam logic [6:0] OP_SECURE_PAGE  = 7'h03;
  localparam logic [6:0] OP_SECURE_CHIP  = 7'h05;
  localparam logic [6:0] OP_BOOT_OPTION  = 7'h08;
  localparam logic [6:0] OP_BOOT_VECTOR  = 7'h09;
  localparam logic [6:0] OP_SECTOR_ERASE = 7'h0B;
  localparam logic [6:0] OP_BYTE_VERIFY  = 7'h0C;
  localparam logic [6:0] OP_PART0_ERASE  = 7'h0D;
  localparam logic [6:0] OP_BYTE_PROGRAM = 7'h0E;

  // Sub-command selector bases in the high address mailbox
  localparam logic [7:0] SEL_PAGE_BASE = 8'h90;
  localparam logic [7:0] SEL_CHIP_BASE = 8'hB0;
  localparam logic [7:0] SEL_BOOT_BASE = 8'hE0;
  localparam int PAGE_COUNT = 5;
  localparam int CHIP_COUNT = 4;
  localparam int BOOT_COUNT = 3;

  // Info readback indices
  localparam logic [2:0] INFO_MAKER   = 3'h0;
  localparam logic [2:0] INFO_DEV0    = 3'h1;
  localparam logic [2:0] INFO_DEV1    = 3'h2;
  localparam logic [2:0] INFO_VECTOR  = 3'h3;
  localparam logic [2:0] INFO_PAGESEC = 3'h4;
  localparam logic [2:0] INFO_CHIPSEC = 3'h5;

  typedef enum logic [2:0] {
    FOP_NONE        = 3'b000,
    FOP_CHIP_ERASE  = 3'b001,
    FOP_SECT_ERASE  = 3'b010,
    FOP_PART0_ERASE = 3'b011,
    FOP_PROGRAM     = 3'b100,
    FOP_READ        = 3'b101
  } flash_op_type;

  typedef struct packed {
    flash_op_type op;
    logic [15:0]  addr;
    logic [7:0]   wdata;
  } flash_req_type;

endpackage : flash_iap_pkg

// file: verification/flash_iap_command_port_asserts.sv
// Checker for the flash command port, bound to its top module.
// Assumes word-aligned APB and a flash answering on the same clock.
`timescale 1ns/1ps
`default_nettype none
module flash_iap_command_port_asserts
  import flash_iap_pkg::*;
(
  input wire logic          sys_clk,
  input wire logic          rstn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [11:0]   paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input wire logic          irq,
  input var  flash_req_type flash_req,
  input wire logic          flash_start,
  input wire logic          flash_done,
  input wire logic [7:0]    flash_rdata
);
  logic [7:0] lo_q;
  logic       vfy_q;
  logic [7:0] hi_q;
  logic [7:0] dat_q;
  logic       busy_q;
  wire  logic wr = psel && penable && pready && pwrite;
  wire  logic wr_cmd = wr && paddr == {2'b00, IDX_COMMAND, 2'b00};

  function automatic flash_op_type op_of(input logic [6:0] c);
    case (c)
      OP_CHIP_ERASE:   return FOP_CHIP_ERASE;
      OP_SECTOR_ERASE: return FOP_SECT_ERASE;
      OP_PART0_ERASE:  return FOP_PART0_ERASE;
      OP_BYTE_PROGRAM: return FOP_PROGRAM;
      OP_BYTE_VERIFY:  return FOP_READ;
      default:         return FOP_NONE;
    endcase
  endfunction : op_of

  // Shadow of the mailboxes; verify data lands the cycle after its start
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lo_q <= 8'h00;
      hi_q <= 8'h00;
      dat_q <= 8'h00;
      vfy_q <= 1'b0;
    end else begin
      vfy_q <= flash_start && flash_req.op == FOP_READ;
      if (wr) begin
        if (paddr == {2'b00, IDX_ADDR_LOW, 2'b00}) lo_q <= pwdata[7:0];
        if (paddr == {2'b00, IDX_ADDR_HIGH, 2'b00}) hi_q <= pwdata[7:0];
        if (paddr == {2'b00, IDX_DATA, 2'b00}) dat_q <= pwdata[7:0];
      end
      // Verify result beats a same-cycle software write
      if (vfy_q) dat_q <= flash_rdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) busy_q <= 1'b0;
    else if (flash_start && flash_req.op != FOP_READ) busy_q <= 1'b1;
    else if (flash_done) busy_q <= 1'b0;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  AST_APB_WAIT: assert property (
    psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  AST_READY_PULSE: assert property (
    pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_ERR_MISALIGN: assert property (
    pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  AST_START_CAUSE: assert property (
    flash_start |-> $past(wr_cmd))
    else $error("flash start without command write");
  AST_OPCODE_MAP: assert property (
    flash_start |-> flash_req.op == op_of($past(pwdata[6:0])))
    else $error("operation decoded wrongly");
  AST_NO_RESERVED: assert property (
    wr_cmd && op_of(pwdata[6:0]) == FOP_NONE |=> !flash_start)
    else $error("flash started by a non-flash code");
  AST_MAILBOX_ADDR: assert property (
    flash_start |-> flash_req.addr == {hi_q, lo_q})
    else $error("request address differs from mailboxes");
  AST_PROGRAM_DATA: assert property (
    flash_start && flash_req.op == FOP_PROGRAM
    |-> flash_req.wdata == dat_q)
    else $error("program data differs from mailbox");
  AST_VERIFY_QUIET: assert property (
    flash_start && flash_req.op == FOP_READ && !irq |=> !irq [*4])
    else $error("verify raised the interrupt");
  AST_ONE_AT_A_TIME: assert property (
    flash_start |-> !busy_q)
    else $error("second start while flash busy");

  COV_PROGRAM: cover property (flash_start && flash_req.op == FOP_PROGRAM);
  COV_VERIFY: cover property (flash_start && flash_req.op == FOP_READ);
  COV_ERR: cover property (pready && pslverr);
  COV_IRQ: cover property ($rose(irq));
endmodule : flash_iap_command_port_asserts

bind flash_iap_command_port flash_iap_command_port_asserts i_asserts (
  .sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .irq, .flash_req, .flash_start, .flash_done, .flash_rdata);
`default_nettype wire

// file: verification/flash_model.sv
// Behavioural flash macro: done pulse DELAY+1 cycles after an erase or
// program start, verify data the cycle after start. Same clock as core.
`timescale 1ns/1ps
`default_nettype none
module flash_model
  import flash_iap_pkg::*;
#(
  parameter int DELAY = 3
) (
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  var  flash_req_type flash_req,
  input  wire logic          flash_start,
  output logic               flash_done,
  output logic [7:0]         flash_rdata,
  output flash_req_type      last_req,
  output int                 n_starts
);
  int cnt;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      flash_done <= 1'b0;
      flash_rdata <= 8'h00;
      n_starts <= 0;
      last_req <= '0;
    end else begin
      flash_done <= (cnt == 1);
      if (cnt != 0) cnt <= cnt - 1;
      // Toggles when idle so stale data never looks valid
      flash_rdata <= ~flash_rdata;
      if (flash_start) begin
        n_starts <= n_starts + 1;
        last_req <= flash_req;
        if (flash_req.op == FOP_READ) flash_rdata <= flash_req.addr[7:0] ^ 8'h5C;
        else cnt <= DELAY;
      end
    end
  end
endmodule : flash_model
`default_nettype wire

// file: verification/flash_iap_command_port_tb_top.sv
// Testbench for the flash command port: APB tasks and directed tests.
// Assumes the behavioural flash model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module flash_iap_command_port_tb_top;
  import flash_iap_pkg::*;
  localparam logic [7:0] ID_M = 8'h6B; // Arbitrary value
  localparam logic [7:0] ID_0 = 8'h1E; // Arbitrary value
  localparam logic [7:0] ID_1 = 8'h47; // Arbitrary value
  logic          sys_clk = 1'b0;
  logic          rstn = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0000_0000;
  logic [1:0]    port1_pins = 2'b00;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          irq;
  flash_req_type flash_req;
  flash_req_type last_req;
  logic          flash_start;
  logic          flash_done;
  logic [7:0]    flash_rdata;
  int            n_starts;
  int            n_fail = 0;
  int            samples_checked = 0;
  logic [31:0]   r;
  logic          e;
  int            i;
  int            n;
  logic [6:0]    codes[3] = '{OP_CHIP_ERASE, OP_SECTOR_ERASE, OP_PART0_ERASE};
  flash_op_type  fops[3] = '{FOP_CHIP_ERASE, FOP_SECT_ERASE, FOP_PART0_ERASE};
  logic [7:0]    info[6] = '{ID_M, ID_0, ID_1, 8'h77, 8'h04, 8'h28};

  always #20 sys_clk = ~sys_clk;

  flash_iap_command_port #(.MAKER_ID(ID_M), .DEVICE_ID0(ID_0),
    .DEVICE_ID1(ID_1))
    i_flash_iap_command_port (.sys_clk, .rstn, .ce(1'b1), .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .port1_pins,
    .flash_req, .flash_start, .flash_done, .flash_rdata);

  flash_model i_flash_model (.sys_clk, .rstn, .flash_req, .flash_start,
    .flash_done, .flash_rdata, .last_req, .n_starts);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    // Wait states come from the slave; only the watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {2'b00, idx, 2'b00}, d);
  endtask : wr

  task automatic rd(input logic [7:0] idx);
    apb(1'b0, {2'b00, idx, 2'b00}, 8'h00);
  endtask : rd

  task automatic cmd(input logic [6:0] op);
    wr(IDX_UNLOCK_1, 8'hAA);
    wr(IDX_UNLOCK_2, 8'h55);
    wr(IDX_COMMAND, {1'b0, op});
  endtask : cmd

  task automatic wait_done;
    for (int k = 0; k < 20; k++) begin
      rd(IDX_CONFIG);
      if (r[7] === 1'b1) break;
    end
  endtask : wait_done

  task automatic rst(input logic [1:0] pins);
    rstn <= 1'b0;
    port1_pins <= pins;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    // Strap is captured a few edges after release
    repeat (6) @(posedge sys_clk);
  endtask : rst

  task automatic final_report;
    if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    final_report();
  end

  initial begin
    rst(2'b00);
    rd(IDX_CONFIG);
    chk(r, 32'h90);
    rd(IDX_COMMAND);
    chk(r, 32'h00);
    cmd(OP_BYTE_PROGRAM);
    rd(IDX_CONFIG);
    chk(r, 32'h10);
    rd(IDX_IRQ_STATUS);
    chk(r, 32'h02);
    chk({31'h0, irq}, 32'h0);
    wr(IDX_IRQ_STATUS, 8'h03);
    wr(IDX_CONFIG, 8'h40);
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_ADDR_LOW, 8'h34);
    wr(IDX_ADDR_HIGH, 8'h12);
    wr(IDX_DATA, 8'hA5);
    cmd(OP_BYTE_PROGRAM);
    wait_done();
    chk(32'(last_req),
        32'({FOP_PROGRAM, 16'h1234, 8'hA5}));
    rd(IDX_CONFIG);
    chk(r, 32'hD0);
    chk({31'h0, irq}, 32'h1);
    wr(IDX_IRQ_STATUS, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    for (i = 0; i < 3; i++) begin
      cmd(codes[i]);
      wait_done();
      chk(32'(last_req.op), 32'(fops[i]));
    end
    wr(IDX_IRQ_STATUS, 8'h03);
    wr(IDX_ADDR_LOW, 8'h21);
    cmd(OP_BYTE_VERIFY);
    wait_done();
    rd(IDX_DATA);
    chk(r, 32'h7D);
    rd(IDX_IRQ_STATUS);
    chk(r, 32'h00);
    n = n_starts;
    foreach (codes[k]) begin
      cmd(7'h02 + 7'(k) * 7'h3D);
      rd(IDX_CONFIG);
      chk({31'h0, r[7]}, 32'h0);
    end
    wr(IDX_UNLOCK_1, 8'hAA);
    wr(IDX_DATA, 8'h00);
    wr(IDX_UNLOCK_2, 8'h55);
    wr(IDX_COMMAND, 8'h8E);
    // A wrongful start reaches the model's count two edges later
    repeat (2) @(posedge sys_clk);
    chk(32'(n_starts), 32'(n));
    rd(IDX_COMMAND);
    chk(r, 32'h0E);
    wr(IDX_ADDR_HIGH, 8'h92);
    cmd(OP_SECURE_PAGE);
    wr(IDX_ADDR_HIGH, 8'hB3);
    cmd(OP_SECURE_CHIP);
    wr(IDX_ADDR_HIGH, 8'hE1);
    cmd(OP_BOOT_OPTION);
    wr(IDX_DATA, 8'h77);
    cmd(OP_BOOT_VECTOR);
    for (i = 0; i < 6; i++) begin
      wr(IDX_CONFIG, 8'h40 | 8'(i));
      rd(IDX_INFO);
      chk(r, 32'(info[i]));
    end
    apb(1'b0, 12'h2C5, 8'h00);
    chk({31'h0, e}, 32'h1);
    rd(8'h10);
    chk({31'h0, e}, 32'h1);
    rst(2'b01);
    rd(IDX_CONFIG);
    chk(r, 32'h80);
    final_report();
  end
endmodule : flash_iap_command_port_tb_top
`default_nettype wire
